// ### hdl/thermo_regs.svh
`ifndef THERMO_REGS_SVH
`define THERMO_REGS_SVH

// scratchpad byte offsets
`define PAD_TEMP_LOW 4'h0
`define PAD_TEMP_HIGH 4'h1
`define PAD_UPPER_LIMIT 4'h2
`define PAD_LOWER_LIMIT 4'h3
`define PAD_RESERVED_A 4'h4
`define PAD_RESERVED_B 4'h5
`define PAD_RESIDUAL 4'h6
`define PAD_COUNTS_PER_DEG 4'h7
`define PAD_CHECK_BYTE 4'h8

// field positions
`define TEMP_CMP_MSB 8
`define TEMP_CMP_LSB 1
`define PAD_BITS 7'h48
`define ROM_CRC_BITS 56

// reset and fixed values
`define TEMP_RESET 16'h00aa
`define RESERVED_VALUE 8'hff
`define COUNTS_PER_DEG_VALUE 8'h10
`define NV_UPPER_RESET 8'h7f
`define NV_LOWER_RESET 8'h80
`define CRC_POLY_REFLECTED 8'h8c

// timing
`define CLOCK_MHZ 200
`define STORE_TIME_US 10000
`define RECALL_CYCLES 5'h10

`endif

// ### hdl/thermo_pkg.sv
package thermo_pkg;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_read_pad = 3'b001,
        st_write_pad = 3'b010,
        st_supply = 3'b011,
        st_recall = 3'b100,
        st_convert = 3'b101,
        st_store = 3'b110
    } state_t;

    typedef enum logic [7:0] {
        cmd_convert = 8'h44,
        cmd_store = 8'h48,
        cmd_write_pad = 8'h4e,
        cmd_read_pad = 8'hbe,
        cmd_supply_query = 8'hb4,
        reload_limits_cmd = 8'hb8
    } cmd_t;

endpackage : thermo_pkg

// ### hdl/crc_if.sv
`timescale 1ns/1ps
`default_nettype none

interface crc_if #(parameter int NBITS = 64);
    logic [NBITS-1:0] data;
    logic [7:0] crc;
    modport src(output data, input crc);
    modport calc(input data, output crc);
endinterface : crc_if

`default_nettype wire

// ### hdl/crc8_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "thermo_regs.svh"

module crc8_unit #(
    parameter int NBITS = 64
) (
    crc_if.calc port
);
    // bits enter lsb first, shift register starts at zero
    always_comb begin
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        fb = 1'b0;
        for (int i = 0; i < NBITS; i++) begin
            fb = c[0] ^ port.data[i];
            c = c >> 1;
            if (fb) begin
                c = c ^ `CRC_POLY_REFLECTED;
            end
        end
        port.crc = c;
    end
endmodule : crc8_unit

`default_nettype wire

// ### hdl/thermometer_scratchpad_alarm.sv
// Overview of operation
// - alarm compares temperature bits 8..1 against the one-byte limits.
// - alarm set when result above upper limit or below lower limit.
// - alarm flag re-evaluated after every conversion, clearing stale alarms.
// - device joins the alarm poll only while its alarm flag is set.
// - supply query read slot pulls low when parasite powered.
// - identity code: family byte, 48-bit serial, crc over lower 56 bits.
// - scratchpad bytes 0 and 1 give temperature low/high, read-only.
// - bytes 2 and 3 give read/write upper and lower limits.
// - bytes 4 and 5 ignore writes and read as all ones.
// - bytes 6 and 7 hold residual count and counts per degree.
// - byte 8 is read-only crc over bytes 0 to 7.
// - write scratchpad loads bytes 2 and 3 only, byte 2 first.
// - read scratchpad shifts out from lsb of byte 0.
// - store command copies both limit bytes into nonvolatile storage.
// - limits reload from nonvolatile storage at power-up.
// - reload command restores limits; slots answer 0 busy, 1 done.
// - temperature holds +85 degrees value until first conversion.
// - all bytes move least significant bit first.
// - both crcs use polynomial x^8 + x^5 + x^4 + 1.
// - scratchpad crc recomputed whenever bytes 0 to 7 change.
`timescale 1ns/1ps
`default_nettype none
`include "thermo_regs.svh"

module thermometer_scratchpad_alarm #(
    parameter int STORE_CYCLES = `STORE_TIME_US * `CLOCK_MHZ,
    parameter logic [7:0] FAMILY_CODE = 8'h5a,     // arbitrary value
    parameter logic [47:0] SERIAL_NUMBER = 48'h0123_4567_89ab // arbitrary
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic wr_byte_valid,
    input wire logic [7:0] wr_byte,
    input wire logic slot_req,
    input wire logic parasite_pin,
    input wire logic conv_done,
    input wire logic [15:0] conv_temp,
    input wire logic [7:0] conv_residual,
    output logic conv_start,
    output logic slot_bit,
    output logic slot_pull_low,
    output logic alarm_flag,
    output logic alarm_poll_en,
    output logic [63:0] rom_code,
    output logic [71:0] pad_image,
    output thermo_pkg::state_t state
);
    import thermo_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // storage
    logic [15:0] temp_q;
    logic [7:0] residual_q;
    logic [7:0] upper_q;
    logic [7:0] lower_q;
    logic [7:0] nv_upper_q;
    logic [7:0] nv_lower_q;
    logic [7:0] crc_q;
    logic alarm_q;
    logic conv_seen_q;
    logic conv_busy_q;
    logic conv_start_q;
    state_t state_q;
    logic [6:0] bit_idx_q;
    logic [1:0] wr_cnt_q;
    logic [20:0] store_cnt_q;
    logic [4:0] recall_cnt_q;
    logic slot_bit_q;
    logic par_meta_q;
    logic par_sync_q;
    logic [63:0] rom_q;
    logic [63:0] pad_lo;
    logic [71:0] pad;
    logic answer;
    logic signed [7:0] temp_cmp;

    crc_if #(.NBITS(64)) pad_crc ();
    crc_if #(.NBITS(`ROM_CRC_BITS)) rom_crc ();

    crc8_unit #(.NBITS(64)) pad_crc_unit (.port(pad_crc.calc));
    crc8_unit #(.NBITS(`ROM_CRC_BITS)) rom_crc_unit (.port(rom_crc.calc));

    // byte n sits at bits 8n+7..8n, so bit 0 leaves first
    assign pad_lo = {`COUNTS_PER_DEG_VALUE, residual_q,
                     `RESERVED_VALUE, `RESERVED_VALUE,
                     lower_q, upper_q, temp_q};
    assign pad = {crc_q, pad_lo};
    assign pad_crc.data = pad_lo;
    assign rom_crc.data = {SERIAL_NUMBER, FAMILY_CODE};
    assign temp_cmp = temp_q[`TEMP_CMP_MSB:`TEMP_CMP_LSB];

    ////////////////////////////////////////////////////////////////////////
    // supply strap synchroniser
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            par_meta_q <= 1'b0;
            par_sync_q <= 1'b0;
        end else if (ce) begin
            par_meta_q <= parasite_pin;
            par_sync_q <= par_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequencer; reset starts a reload so limits come from storage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= st_recall;
            bit_idx_q <= 7'h00;
            wr_cnt_q <= 2'h0;
            store_cnt_q <= 21'h000000;
            recall_cnt_q <= `RECALL_CYCLES;
        end else if (ce) begin
            if (state_q == st_store) begin
                if (store_cnt_q == 21'h000001) begin
                    state_q <= st_idle;
                end
                store_cnt_q <= store_cnt_q - 21'h000001;
            end else if (state_q == st_recall && recall_cnt_q != 5'h00) begin
                recall_cnt_q <= recall_cnt_q - 5'h01;
            end else if (cmd_valid) begin
                // nv transfers in flight finish before new commands
                case (cmd_code)
                    cmd_convert: state_q <= st_convert;
                    cmd_store: begin
                        state_q <= st_store;
                        store_cnt_q <= 21'(STORE_CYCLES);
                    end
                    cmd_write_pad: begin
                        state_q <= st_write_pad;
                        wr_cnt_q <= 2'h0;
                    end
                    cmd_read_pad: begin
                        state_q <= st_read_pad;
                        bit_idx_q <= 7'h00;
                    end
                    cmd_supply_query: state_q <= st_supply;
                    reload_limits_cmd: begin
                        state_q <= st_recall;
                        recall_cnt_q <= `RECALL_CYCLES;
                    end
                    default: state_q <= st_idle;
                endcase
            end else begin
                // saturates at two so a third byte finds no target
                if (state_q == st_write_pad && wr_byte_valid
                    && wr_cnt_q != 2'h2) begin
                    wr_cnt_q <= wr_cnt_q + 2'h1;
                end
                if (state_q == st_read_pad && slot_req
                    && bit_idx_q != `PAD_BITS) begin
                    bit_idx_q <= bit_idx_q + 7'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // limits and their nonvolatile copies
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            upper_q <= 8'h00;
            lower_q <= 8'h00;
            nv_upper_q <= `NV_UPPER_RESET;
            nv_lower_q <= `NV_LOWER_RESET;
        end else if (ce) begin
            if (state_q == st_recall && recall_cnt_q == 5'h01) begin
                upper_q <= nv_upper_q;
                lower_q <= nv_lower_q;
            end else if (state_q == st_write_pad && !cmd_valid
                         && wr_byte_valid) begin
                // only two bytes land; a third is dropped
                if (wr_cnt_q == 2'h0) begin
                    upper_q <= wr_byte;
                end else if (wr_cnt_q == 2'h1) begin
                    lower_q <= wr_byte;
                end
            end
            if (state_q == st_store && store_cnt_q == 21'h000001) begin
                nv_upper_q <= upper_q;
                nv_lower_q <= lower_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion results and alarm
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            temp_q <= `TEMP_RESET;
            residual_q <= 8'h00;
            conv_seen_q <= 1'b0;
            alarm_q <= 1'b0;
        end else if (ce && conv_done) begin
            temp_q <= conv_temp;
            residual_q <= conv_residual;
            conv_seen_q <= 1'b1;
            // limits may change later; flag reflects them only here
            alarm_q <= ($signed(conv_temp[`TEMP_CMP_MSB:`TEMP_CMP_LSB])
                        > $signed(upper_q))
                    || ($signed(conv_temp[`TEMP_CMP_MSB:`TEMP_CMP_LSB])
                        < $signed(lower_q));
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            conv_busy_q <= 1'b0;
            conv_start_q <= 1'b0;
        end else if (ce) begin
            conv_start_q <= cmd_valid && cmd_code == cmd_convert
                            && state_q != st_store
                            && !(state_q == st_recall
                                 && recall_cnt_q != 5'h00);
            if (conv_start_q) begin
                conv_busy_q <= 1'b1;
            end else if (conv_done) begin
                conv_busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            crc_q <= 8'h00;
            rom_q <= 64'h0;
        end else if (ce) begin
            crc_q <= pad_crc.crc;
            rom_q <= {rom_crc.crc, SERIAL_NUMBER, FAMILY_CODE};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read slot answers; a 0 means the line is pulled low
    always_comb begin
        case (state_q)
            st_read_pad: answer = (bit_idx_q == `PAD_BITS) ? 1'b1
                                  : pad[bit_idx_q];
            st_supply: answer = ~par_sync_q;
            st_recall: answer = (recall_cnt_q == 5'h00);
            st_convert: answer = ~(conv_busy_q || conv_start_q);
            st_store: answer = 1'b0;
            default: answer = 1'b1;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            slot_bit_q <= 1'b1;
        end else if (ce) begin
            if (slot_req) begin
                slot_bit_q <= answer;
            end
        end
    end

    assign slot_bit = slot_bit_q;
    assign slot_pull_low = ~slot_bit_q;
    assign conv_start = conv_start_q;
    assign alarm_flag = alarm_q;
    assign alarm_poll_en = alarm_q;
    assign rom_code = rom_q;
    assign pad_image = pad;
    assign state = state_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    alarm_eval_a: assert property (ce && conv_done |=> alarm_q ==
        ((temp_cmp > $signed($past(upper_q)))
        || (temp_cmp < $signed($past(lower_q)))))
        else $error("alarm flag disagrees with last result");
    poll_follow_a: assert property ($rose(alarm_poll_en) |->
        $past(conv_done) && $past(ce))
        else $error("alarm poll enabled without a conversion");
    reserved_ones_a: assert property (pad[47:32] == 16'hffff)
        else $error("reserved bytes not all ones");
    temp_power_a: assert property (!conv_seen_q |-> temp_q == 16'h00aa)
        else $error("temperature lost power-on value");
    write_upper_a: assert property (ce && state_q == st_write_pad
        && !cmd_valid && wr_byte_valid && wr_cnt_q == 2'h0
        |=> upper_q == $past(wr_byte) && $stable(temp_q))
        else $error("first written byte not in upper limit");
    write_third_a: assert property (ce && state_q == st_write_pad
        && !cmd_valid && wr_byte_valid && wr_cnt_q == 2'h2
        |=> $stable(upper_q) && $stable(lower_q))
        else $error("third written byte changed a limit");
    crc_track_a: assert property (ce && $past(ce) && $past(arst_n)
        && $stable(pad_lo) |-> crc_q == pad_crc.crc)
        else $error("check byte stale");
    supply_slot_a: assert property (ce && slot_req
        && state_q == st_supply |=> slot_pull_low == $past(par_sync_q))
        else $error("supply query answered wrongly");
    recall_busy_a: assert property (ce && slot_req
        && state_q == st_recall && recall_cnt_q != 5'h00
        |=> slot_pull_low)
        else $error("reload in progress answered as done");
    store_copy_a: assert property (ce && state_q == st_store
        && store_cnt_q == 21'h000001
        |=> nv_upper_q == $past(upper_q) && nv_lower_q == $past(lower_q)
        && state_q == st_idle)
        else $error("store did not copy limits");
    read_first_a: assert property (ce && cmd_valid
        && cmd_code == cmd_read_pad && state_q == st_idle
        |=> state_q == st_read_pad && bit_idx_q == 7'h00)
        else $error("read scratchpad not at bit zero");

    alarm_set_c: cover property (ce && conv_done ##1 alarm_q);
    read_walk_c: cover property (state_q == st_read_pad
        && bit_idx_q == 7'h48);
    store_done_c: cover property (state_q == st_store ##1 state_q == st_idle);
    recall_done_c: cover property (ce && slot_req && state_q == st_recall
        && recall_cnt_q == 5'h00);
endmodule : thermometer_scratchpad_alarm

`default_nettype wire

// ### sim/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// far-side master: sends commands and data bytes, takes read slots
module bus_master_model (
    input wire logic clock,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic wr_byte_valid,
    output logic [7:0] wr_byte,
    output logic slot_req,
    input wire logic slot_bit
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        wr_byte_valid = 1'b0;
        wr_byte = 8'h00;
        slot_req = 1'b0;
    end

    ////////////////////////////////////////
    // released fields show the inverse so a stale value never matches
    task send_cmd(input logic [7:0] c);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd_code <= ~c;
    endtask : send_cmd

    task send_byte(input logic [7:0] d);
        @(posedge clock);
        wr_byte_valid <= 1'b1;
        wr_byte <= d;
        @(posedge clock);
        wr_byte_valid <= 1'b0;
        wr_byte <= ~d;
    endtask : send_byte

    task read_slot(output logic b);
        @(posedge clock);
        slot_req <= 1'b1;
        @(posedge clock);
        slot_req <= 1'b0;
        #1;
        b = slot_bit;
    endtask : read_slot

    // quiet bus while the strong pullup would be on
    task idle_bus(input int n);
        repeat (n) @(posedge clock);
    endtask : idle_bus
endmodule : bus_master_model

`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import thermo_pkg::*;
    localparam int STORE_N = 20;
    // arbitrary identity value
    localparam logic [55:0] ROM_LOW = {48'h2468_ace0_1357, 8'h3c};
    logic clock;
    logic ce;
    logic arst_n;
    logic parasite_pin;
    logic conv_done;
    logic [15:0] conv_temp;
    logic [7:0] conv_residual;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic wr_byte_valid;
    logic [7:0] wr_byte;
    logic slot_req;
    logic conv_start;
    logic slot_bit;
    logic slot_pull_low;
    logic alarm_flag;
    logic alarm_poll_en;
    logic [63:0] rom_code;
    logic [71:0] pad_image;
    state_t state;
    int n_mismatch;
    int n_tests;
    logic b;
    logic [7:0] up;
    logic [7:0] lo;
    logic [71:0] exp_pad;

    thermometer_scratchpad_alarm #(
        .STORE_CYCLES(STORE_N),
        .FAMILY_CODE(ROM_LOW[7:0]),
        .SERIAL_NUMBER(ROM_LOW[55:8])
    ) u_dut (
        .clock(clock), .arst_n(arst_n), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
        .slot_req(slot_req), .parasite_pin(parasite_pin),
        .conv_done(conv_done), .conv_temp(conv_temp),
        .conv_residual(conv_residual), .conv_start(conv_start),
        .slot_bit(slot_bit), .slot_pull_low(slot_pull_low),
        .alarm_flag(alarm_flag), .alarm_poll_en(alarm_poll_en),
        .rom_code(rom_code), .pad_image(pad_image), .state(state)
    );

    bus_master_model u_m (
        .clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
        .slot_req(slot_req), .slot_bit(slot_bit)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    ////////////////////////////////////////
    // bit-serial, lsb first, matching how the master checks it
    function automatic logic [7:0] crc8(input logic [71:0] d, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
        end
        return c;
    endfunction : crc8

    function automatic logic [71:0] pad_exp(input logic [15:0] t,
                                            input logic [7:0] r);
        logic [63:0] x;
        x = {8'h10, r, 16'hffff, lo, up, t};
        return {crc8({8'h00, x}, 64), x};
    endfunction : pad_exp

    task chk(input logic [71:0] got, input logic [71:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task test_done;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task convert(input logic [15:0] t, input logic exp_alarm);
        int i;
        u_m.send_cmd(8'h44);
        i = 0;
        #1;
        while (conv_start !== 1'b1 && i < 4) begin
            @(posedge clock);
            #1;
            i++;
        end
        chk(conv_start, 1'b1);
        u_m.read_slot(b);
        chk(b, 1'b0);
        @(posedge clock);
        conv_done <= 1'b1;
        conv_temp <= t;
        conv_residual <= t[7:0] ^ 8'h5a;
        @(posedge clock);
        conv_done <= 1'b0;
        conv_temp <= ~t;
        conv_residual <= ~t[7:0];
        repeat (2) @(posedge clock);
        #1;
        chk(alarm_flag, exp_alarm);
        chk(alarm_poll_en, exp_alarm);
        chk(pad_image, pad_exp(t, t[7:0] ^ 8'h5a));
        u_m.read_slot(b);
        chk(b, 1'b1);
    endtask : convert

    ////////////////////////////////////////
    initial begin
        repeat (2000) @(posedge clock);
        n_mismatch++;
        test_done();
    end

    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        parasite_pin = 1'b0;
        conv_done = 1'b0;
        conv_temp = 16'h0000;
        conv_residual = 8'h00;
        n_mismatch = 0;
        n_tests = 0;
        up = 8'h7f;
        lo = 8'h80;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (20) @(posedge clock);
        #1;
        exp_pad = pad_exp(16'h00aa, 8'h00);
        chk(pad_image[47:0], exp_pad[47:0]);
        chk(pad_image[63:56], 8'h10);
        chk(rom_code, {crc8({16'h0000, ROM_LOW}, 56), ROM_LOW});
        for (int p = 0; p < 2; p++) begin
            @(posedge clock);
            parasite_pin <= p[0];
            repeat (4) @(posedge clock);
            u_m.send_cmd(8'hb4);
            u_m.read_slot(b);
            chk(slot_pull_low, p[0]);
        end
        // third byte must not spill into the reserved bytes
        u_m.send_cmd(8'h4e);
        u_m.send_byte(8'h19);
        u_m.send_byte(8'hf6);
        u_m.send_byte(8'h77);
        up = 8'h19;
        lo = 8'hf6;
        @(posedge clock);
        #1;
        exp_pad = pad_exp(16'h00aa, 8'h00);
        chk(pad_image[47:0], exp_pad[47:0]);
        convert(16'h0034, 1'b1);
        convert(16'h0033, 1'b0);
        convert(16'hffea, 1'b1);
        convert(16'hffed, 1'b0);
        u_m.send_cmd(8'hbe);
        exp_pad = pad_exp(16'hffed, 8'hb7);
        for (int i = 0; i < 72; i++) begin
            u_m.read_slot(b);
            chk(b, exp_pad[i]);
        end
        u_m.read_slot(b);
        chk(b, 1'b1);
        // frozen enable: a result arriving now must leave no trace
        @(posedge clock);
        ce <= 1'b0;
        conv_done <= 1'b1;
        conv_temp <= 16'h0100;
        repeat (2) @(posedge clock);
        ce <= 1'b1;
        conv_done <= 1'b0;
        @(posedge clock);
        #1;
        chk(alarm_flag, 1'b0);
        chk(pad_image, exp_pad);
        // command in mid-store breaks the quiet-bus rule and is dropped
        u_m.send_cmd(8'h48);
        u_m.idle_bus(5);
        u_m.send_cmd(8'h4e);
        u_m.idle_bus(STORE_N);
        chk(state, st_idle);
        u_m.send_cmd(8'h4e);
        u_m.send_byte(8'h55);
        u_m.send_byte(8'h66);
        u_m.send_cmd(8'hb8);
        u_m.read_slot(b);
        chk(b, 1'b0);
        u_m.idle_bus(20);
        u_m.read_slot(b);
        chk(b, 1'b1);
        chk(pad_image, exp_pad);
        test_done();
    end
endmodule : testbench

`default_nettype wire
